// ### host_link_model.sv
/*
 Host controller model: chip select, serial clock and the four lines.
 Assumes ioWire is the resolved wire level fed back by the bench.
*/
`timescale 1ns/100ps
module host_link_model (
   input  wire [3:0] ioWire,
   output reg        csN,
   output reg        sclk,
   output reg  [3:0] ioDrv
);
   reg [3:0] nib [0:15];
   integer   i;
   initial
   begin
      csN = 1'b1;
      sclk = 1'b0;
      ioDrv = 4'h0;
   end
   // Lines settle half way through each half period
   task step(input [3:0] v);
   begin
      #40 ioDrv = v;
      #40 sclk = ~sclk;
   end
   endtask
   task xfer(input sendOp, input quad, input [7:0] op, input [3:0] nAdr,
             input [31:0] adr, input [7:0] mode, input [3:0] nDum, input [4:0] nNib);
   begin
      csN = 1'b0;
      if (sendOp && quad)
         for (i = 0; i < 4; i = i + 1)
            step(i < 2 ? op[7:4] : op[3:0]);
      else if (sendOp)
         for (i = 0; i < 16; i = i + 1)
            step({3'h0, op[7 - i / 2]});
      for (i = 0; i < nAdr; i = i + 1)
         step(adr[4 * (nAdr - 1 - i) +: 4]);
      step(mode[7:4]);
      step(mode[3:0]);
      // Released lines keep changing so a stale level is never read back
      for (i = 2; i < 2 * nDum; i = i + 1)
         step(~ioDrv);
      for (i = 0; i < nNib; i = i + 1)
      begin
         #80 nib[i] = ioWire;
         sclk = ~sclk;
      end
      #40 csN = 1'b1;
      ioDrv = ~ioDrv;
      #40 sclk = 1'b0;
      #160;
   end
   endtask
endmodule

// ### pair_buffer.v
/*
 Two-entry valid/ready buffer between the array read port and the
 nibble serializer.
 Assumes both sides run on clk; inReady falls when both entries are full.
*/
`timescale 1ns/100ps
`include "qdtr_defines.vh"

module pair_buffer #(
   parameter W = `BUF_W
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire         inValid,
   output wire         inReady,
   input  wire [W-1:0] inData,
   output wire         outValid,
   input  wire         outReady,
   output wire [W-1:0] outData,
   output wire [1:0]   count
);

   reg [W-1:0] mem [0:1];
   reg         wrPtr_ff;
   reg         rdPtr_ff;
   reg [1:0]   cnt_ff;

   wire push = inValid & inReady;
   wire pop  = outValid & outReady;

   assign inReady  = (cnt_ff != 2'h2);
   assign outValid = (cnt_ff != 2'h0);
   assign outData  = mem[rdPtr_ff];
   assign count    = cnt_ff;

   always @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr_ff] <= inData;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         wrPtr_ff <= 1'b0;
         rdPtr_ff <= 1'b0;
         cnt_ff   <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_ff <= ~wrPtr_ff;
         end
         if (pop)
         begin
            rdPtr_ff <= ~rdPtr_ff;
         end
         if (push & ~pop)
         begin
            cnt_ff <= cnt_ff + 2'h1;
         end
         else if (pop & ~push)
         begin
            cnt_ff <= cnt_ff - 2'h1;
         end
      end
   end

endmodule

// ### qdtr_defines.vh
/*
 Constants for the quad DTR read path: opcodes, phase lengths, mode-bit
 code, bank register layout and buffer depth.
 Assumes inclusion by bare name from the design files.
*/
`ifndef QDTR_DEFINES_VH
`define QDTR_DEFINES_VH

// Read opcodes
`define OP_QDTR       8'hED
`define OP_QDTR4      8'hEE

// Opcode length in rising edges
`define OPC_SPI_CLKS  4'h8
`define OPC_QPI_CLKS  4'h2

// Address length in nibbles
`define ADDR_NIB3     4'h6
`define ADDR_NIB4     4'h8

// Dummy clocks used when the configuration reads zero
`define DUMMY_DEF     4'h6

// Upper mode nibble that keeps continuous read
`define MODE_CONT     4'hA

// Bank register layout
`define BANK_EXT_BIT  7
`define BANK_HI_MSB   6

// Address wrap point and step
`define ARRAY_LAST    32'hFFFFFFFF
`define ADDR_ZERO     32'h00000000
`define ADDR_STEP     32'h00000001

// Response buffer
`define BUF_DEPTH     3'h2
`define BUF_W         8

`endif

// ### quad_dtr_read_path.v
/*
 Quad I/O double-transfer-rate read path of a serial flash, on the device
 side of the link: opcode decode, address capture, dummy and mode bits,
 continuous read, and nibble output on both serial clock edges.
 Assumes chip select, serial clock and I/O lines come from the host in
 another clock domain, oversampled by clk; array bytes arrive over a
 valid/ready read port.
*/
// What this block does
// - Eight bits per clock, nibble per edge
// - Start address may be any byte
// - Address steps per byte, wraps to zero
// - EDh three or four bytes, EEh four
// - SPI-mode opcode on line zero, eight clocks
// - Opcode, address, dummy, then data order
// - Dummy clock count configurable, default six
// - Chip select high stops data anytime
// - Upper mode nibble A enters continuous read
// - Other mode nibble leaves continuous read
// - After leaving, next transaction needs opcode
// - Read ignored while write in progress
// - Quad-mode opcode four bits per clock
// - Quad mode skips quad enable check
// - Continuous read works in quad mode
// - Extended address enable is bank bit seven
// - Bank bits supply high address bits
`timescale 1ns/100ps
`include "qdtr_defines.vh"

module quad_dtr_read_path (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        csN,
   input  wire        sclk,
   input  wire [3:0]  ioIn,
   output wire [3:0]  ioOut,
   output wire [3:0]  ioOe,
   input  wire        quadEnable,
   input  wire        quadCmdMode,
   input  wire [7:0]  bankReg,
   input  wire        writeInProgress,
   input  wire [3:0]  dummyCfg,
   output wire        contReadMode,
   output wire        memReqValid,
   input  wire        memReqReady,
   output wire [31:0] memReqAddr,
   input  wire        memRspValid,
   output wire        memRspReady,
   input  wire [7:0]  memRspData
);

   localparam [5:0] ST_IDLE  = 6'b000001;
   localparam [5:0] ST_OPC   = 6'b000010;
   localparam [5:0] ST_ADDR  = 6'b000100;
   localparam [5:0] ST_DUMMY = 6'b001000;
   localparam [5:0] ST_DATA  = 6'b010000;
   localparam [5:0] ST_REJ   = 6'b100000;

   function isReadOp;
      input [7:0] op;
      begin
         isReadOp = (op == `OP_QDTR) || (op == `OP_QDTR4);
      end
   endfunction

   function [31:0] startAddr;
      input [31:0] sh;
      input        four;
      input [7:0]  bank;
      begin
         if (four)
         begin
            startAddr = sh;
         end
         else
         begin
            startAddr = {1'b0, bank[`BANK_HI_MSB:0], sh[23:0]};
         end
      end
   endfunction

   function [31:0] stepAddr;
      input [31:0] a;
      begin
         if (a == `ARRAY_LAST)
         begin
            stepAddr = `ADDR_ZERO;
         end
         else
         begin
            stepAddr = a + `ADDR_STEP;
         end
      end
   endfunction

   // Two-stage synchronisers; bit 2 of each shift is the previous sample
   reg  [2:0]  csSync_ff;
   reg  [2:0]  sclkSync_ff;
   reg  [3:0]  ioMeta_ff;
   reg  [3:0]  ioSync_ff;

   reg  [5:0]  state_ff;
   reg  [3:0]  cnt_ff;
   reg  [7:0]  opc_ff;
   reg  [31:0] addrSh_ff;
   reg         four_ff;
   reg         cont_ff;
   reg  [3:0]  modeHi_ff;
   reg  [7:0]  curByte_ff;
   reg  [3:0]  ioOut_ff;
   reg  [3:0]  ioOe_ff;
   reg  [31:0] reqAddr_ff;
   reg  [1:0]  pend_ff;

   reg  [5:0]  nxt_state;
   reg  [3:0]  nxt_cnt;
   reg  [7:0]  nxt_opc;
   reg  [31:0] nxt_addrSh;
   reg         nxt_four;
   reg         nxt_cont;
   reg  [3:0]  nxt_modeHi;
   reg  [7:0]  nxt_curByte;
   reg  [3:0]  nxt_ioOut;
   reg  [3:0]  nxt_ioOe;
   reg  [31:0] nxt_reqAddr;
   reg  [1:0]  nxt_pend;
   reg         popReq;

   wire        csHigh    = csSync_ff[1];
   wire        sclkRise  = sclkSync_ff[1] & ~sclkSync_ff[2];
   wire        sclkFall  = ~sclkSync_ff[1] & sclkSync_ff[2];
   wire        sclkEdge  = sclkRise | sclkFall;
   wire [3:0]  io        = ioSync_ff;

   wire [3:0]  dummyN    = (dummyCfg == 4'h0) ? `DUMMY_DEF : dummyCfg;
   wire [3:0]  addrNibs  = four_ff ? `ADDR_NIB4 : `ADDR_NIB3;
   wire [3:0]  opcClks   = quadCmdMode ? `OPC_QPI_CLKS : `OPC_SPI_CLKS;
   wire [7:0]  opcShift  = quadCmdMode ? {opc_ff[3:0], io} : {opc_ff[6:0], io[0]};

   wire        bufValid;
   wire [7:0]  bufData;
   wire [1:0]  bufCount;
   wire        drain;
   wire        reqFire;
   wire        rspFire;
   wire [2:0]  inFlight;

   // Stale bytes from an ended read are thrown away in the idle, reject, opcode and address states
   assign drain       = (state_ff == ST_IDLE) | (state_ff == ST_REJ) |
                        (state_ff == ST_OPC) | (state_ff == ST_ADDR);
   assign inFlight    = {1'b0, pend_ff} + {1'b0, bufCount};
   assign memReqValid = ((state_ff == ST_DUMMY) | (state_ff == ST_DATA)) &
                        (inFlight < `BUF_DEPTH);
   assign reqFire     = memReqValid & memReqReady;
   assign rspFire     = memRspValid & memRspReady;
   assign memReqAddr  = reqAddr_ff;
   assign ioOut       = ioOut_ff;
   assign ioOe        = ioOe_ff;
   assign contReadMode = cont_ff;

   pair_buffer #(
      .W        (`BUF_W)
   ) rspBuf (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (memRspValid),
      .inReady  (memRspReady),
      .inData   (memRspData),
      .outValid (bufValid),
      .outReady (drain | popReq),
      .outData  (bufData),
      .count    (bufCount)
   );

   always @*
   begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_opc     = opc_ff;
      nxt_addrSh  = addrSh_ff;
      nxt_four    = four_ff;
      nxt_cont    = cont_ff;
      nxt_modeHi  = modeHi_ff;
      nxt_curByte = curByte_ff;
      nxt_ioOut   = ioOut_ff;
      nxt_ioOe    = ioOe_ff;
      nxt_reqAddr = reqAddr_ff;
      popReq      = 1'b0;
      if (reqFire)
      begin
         nxt_reqAddr = stepAddr(reqAddr_ff);
      end
      if (csHigh)
      begin
         nxt_state = ST_IDLE;
         nxt_ioOe  = 4'h0;
         nxt_cnt   = 4'h0;
      end
      else
      begin
         case (state_ff)
            ST_IDLE:
            begin
               nxt_cnt = 4'h0;
               nxt_ioOe = 4'h0;
               if (cont_ff & writeInProgress)
               begin
                  nxt_state = ST_REJ;
               end
               else if (cont_ff)
               begin
                  nxt_state = ST_ADDR;
               end
               else
               begin
                  nxt_state = ST_OPC;
               end
            end
            ST_OPC:
            begin
               if (sclkRise)
               begin
                  nxt_opc = opcShift;
                  nxt_cnt = cnt_ff + 4'h1;
                  if (cnt_ff == opcClks - 4'h1)
                  begin
                     nxt_cnt = 4'h0;
                     // Quad mode accepts the read without quad enable
                     if (isReadOp(opcShift) && !writeInProgress &&
                         (quadCmdMode || quadEnable))
                     begin
                        nxt_state = ST_ADDR;
                        nxt_four  = (opcShift == `OP_QDTR4) |
                                    bankReg[`BANK_EXT_BIT];
                     end
                     else
                     begin
                        nxt_state = ST_REJ;
                     end
                  end
               end
            end
            ST_ADDR:
            begin
               // The fall that closes the last opcode clock carries no address
               if (sclkEdge && (sclkRise || cnt_ff != 4'h0))
               begin
                  nxt_addrSh = {addrSh_ff[27:0], io};
                  nxt_cnt    = cnt_ff + 4'h1;
                  if (cnt_ff == addrNibs - 4'h1)
                  begin
                     nxt_cnt     = 4'h0;
                     nxt_state   = ST_DUMMY;
                     // Any byte address is a legal start
                     nxt_reqAddr = startAddr({addrSh_ff[27:0], io}, four_ff,
                                             bankReg);
                  end
               end
            end
            ST_DUMMY:
            begin
               if (sclkRise && cnt_ff == 4'h0)
               begin
                  nxt_modeHi = io;
               end
               if (sclkFall)
               begin
                  nxt_cnt = cnt_ff + 4'h1;
                  if (cnt_ff == 4'h0)
                  begin
                     // Lower nibble is ignored
                     nxt_cont = (modeHi_ff == `MODE_CONT);
                  end
                  if (cnt_ff == dummyN - 4'h1)
                  begin
                     nxt_cnt     = 4'h0;
                     nxt_state   = ST_DATA;
                     popReq      = bufValid;
                     nxt_curByte = bufValid ? bufData : 8'h00;
                     nxt_ioOut   = bufValid ? bufData[7:4] : 4'h0;
                     nxt_ioOe    = 4'hF;
                  end
               end
            end
            ST_DATA:
            begin
               if (sclkRise)
               begin
                  nxt_ioOut = curByte_ff[3:0];
               end
               else if (sclkFall)
               begin
                  // An empty buffer shows zeros rather than stalling the host
                  popReq      = bufValid;
                  nxt_curByte = bufValid ? bufData : 8'h00;
                  nxt_ioOut   = bufValid ? bufData[7:4] : 4'h0;
               end
            end
            ST_REJ:
            begin
               nxt_ioOe = 4'h0;
            end
            default:
            begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   always @*
   begin
      nxt_pend = pend_ff;
      if (reqFire & ~rspFire)
      begin
         nxt_pend = pend_ff + 2'h1;
      end
      else if (rspFire & ~reqFire & (pend_ff != 2'h0))
      begin
         nxt_pend = pend_ff - 2'h1;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         csSync_ff   <= 3'h7;
         sclkSync_ff <= 3'h0;
         ioMeta_ff   <= 4'h0;
         ioSync_ff   <= 4'h0;
      end
      else
      begin
         csSync_ff   <= {csSync_ff[1:0], csN};
         sclkSync_ff <= {sclkSync_ff[1:0], sclk};
         ioMeta_ff   <= ioIn;
         ioSync_ff   <= ioMeta_ff;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_ff   <= ST_IDLE;
         cnt_ff     <= 4'h0;
         opc_ff     <= 8'h00;
         addrSh_ff  <= 32'h00000000;
         four_ff    <= 1'b0;
         cont_ff    <= 1'b0;
         modeHi_ff  <= 4'h0;
         curByte_ff <= 8'h00;
         ioOut_ff   <= 4'h0;
         ioOe_ff    <= 4'h0;
         reqAddr_ff <= 32'h00000000;
         pend_ff    <= 2'h0;
      end
      else
      begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         opc_ff     <= nxt_opc;
         addrSh_ff  <= nxt_addrSh;
         four_ff    <= nxt_four;
         cont_ff    <= nxt_cont;
         modeHi_ff  <= nxt_modeHi;
         curByte_ff <= nxt_curByte;
         ioOut_ff   <= nxt_ioOut;
         ioOe_ff    <= nxt_ioOe;
         reqAddr_ff <= nxt_reqAddr;
         pend_ff    <= nxt_pend;
      end
   end

endmodule

// ### quad_dtr_read_path_monitor.sv
/*
 Port checker for the quad DTR read path.
 Assumes it is bound to quad_dtr_read_path and sees only its ports.
*/
`timescale 1ns/100ps
module quad_dtr_read_path_monitor (
   input logic        clk,
   input logic        rst_n,
   input logic        csN,
   input logic        sclk,
   input logic [3:0]  ioOut,
   input logic [3:0]  ioOe,
   input logic        writeInProgress,
   input logic        contReadMode,
   input logic        memReqValid,
   input logic        memReqReady,
   input logic [31:0] memReqAddr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic busyFrame_ff;
   // Frame opened while busy stays silent until busy or the frame ends
   always @(posedge clk)
      if (!rst_n || csN || !writeInProgress)
         busyFrame_ff <= 1'b0;
      else if ($fell(csN))
         busyFrame_ff <= 1'b1;
   property p_busyQuiet;
      busyFrame_ff |-> ioOe == 4'h0;
   endproperty
   a_busyQuiet: assert property (p_busyQuiet) else $error("lines driven while busy");
   property p_contChange;
      $changed(contReadMode) |-> $past(csN, 3) == 1'b0;
   endproperty
   a_contChange: assert property (p_contChange) else $error("mode flag moved outside frame");
   property p_oeRise;
      $rose(ioOe[0]) |-> !csN && !$past(csN, 4);
   endproperty
   a_oeRise: assert property (p_oeRise) else $error("drive began without a frame");
   property p_addrStep;
      memReqValid && memReqReady ##1 memReqValid |-> memReqAddr == $past(memReqAddr) + 32'h1;
   endproperty
   a_addrStep: assert property (p_addrStep) else $error("read address did not step by one");
   property p_addrHold;
      memReqValid && !memReqReady |=> !memReqValid || $stable(memReqAddr);
   endproperty
   a_addrHold: assert property (p_addrHold) else $error("address moved while stalled");
   property p_nibbleStill;
      (ioOe == 4'hF && $stable(sclk)) [*3] |=> $stable(ioOut);
   endproperty
   a_nibbleStill: assert property (p_nibbleStill) else $error("nibble moved without edge");
   property p_csHigh;
      csN [*4] |-> ioOe == 4'h0;
   endproperty
   a_csHigh: assert property (p_csHigh) else $error("lines driven after deselect");
   property p_allLines;
      ioOe == 4'h0 || ioOe == 4'hF;
   endproperty
   a_allLines: assert property (p_allLines) else $error("partial line drive");
endmodule

bind quad_dtr_read_path quad_dtr_read_path_monitor quad_dtr_read_path_monitor_inst (
   .clk(clk), .rst_n(rst_n), .csN(csN), .sclk(sclk), .ioOut(ioOut), .ioOe(ioOe),
   .writeInProgress(writeInProgress), .contReadMode(contReadMode),
   .memReqValid(memReqValid), .memReqReady(memReqReady), .memReqAddr(memReqAddr));

// ### tb.sv
/*
 Bench for quad_dtr_read_path: host model on the link, array responder.
 Assumes host_link_model and the bound checker compile beside it.
*/
`timescale 1ns/100ps
module tb;
   reg         clk;
   reg         rst_n;
   reg         quadEnable;
   reg         quadCmdMode;
   reg  [7:0]  bankReg;
   reg         writeInProgress;
   reg  [3:0]  dummyCfg;
   reg         memReqReady;
   reg         memRspValid;
   reg  [7:0]  memRspData;
   reg         oeSeen;
   reg  [31:0] pend [$];
   wire        csN;
   wire        sclk;
   wire [3:0]  ioDrv;
   wire [3:0]  ioOut;
   wire [3:0]  ioOe;
   wire        contReadMode;
   wire        memReqValid;
   wire [31:0] memReqAddr;
   wire        memRspReady;
   wire [3:0]  ioWire = (ioOut & ioOe) | (ioDrv & ~ioOe);
   integer     bad_count = 0;
   integer     checked = 0;
   integer     stalls = 0;
   integer     cyc = 0;

   quad_dtr_read_path quad_dtr_read_path_inst (.clk(clk), .rst_n(rst_n), .csN(csN),
      .sclk(sclk), .ioIn(ioWire), .ioOut(ioOut), .ioOe(ioOe), .quadEnable(quadEnable),
      .quadCmdMode(quadCmdMode), .bankReg(bankReg), .writeInProgress(writeInProgress),
      .dummyCfg(dummyCfg), .contReadMode(contReadMode), .memReqValid(memReqValid),
      .memReqReady(memReqReady), .memReqAddr(memReqAddr), .memRspValid(memRspValid),
      .memRspReady(memRspReady), .memRspData(memRspData));
   host_link_model host_link_model_inst (.ioWire(ioWire), .csN(csN), .sclk(sclk),
      .ioDrv(ioDrv));

   always #10 clk = ~clk;

   function [7:0] byteAt(input [31:0] a);
      byteAt = a[7:0] ^ a[31:24] ^ a[19:12];
   endfunction

   // Array answers a cycle later; ready drops every fifth cycle
   always @(posedge clk)
   begin
      if (memRspValid && memRspReady)
         void'(pend.pop_front());
      if (memReqValid && memReqReady === 1'b0)
         stalls = stalls + 1;
      if (memReqValid && memReqReady)
         pend.push_back(memReqAddr);
      // Requests taken before deselect are still answered
      if (!rst_n)
         pend.delete();
      if (ioOe !== 4'h0)
         oeSeen = 1'b1;
      cyc = cyc + 1;
      #1;
      memReqReady = (cyc % 5) != 2;
      memRspValid = pend.size() != 0;
      memRspData = pend.size() != 0 ? byteAt(pend[0]) : 8'h00;
   end

   task check(input [31:0] seen, input [31:0] exp);
   begin
      checked = checked + 1;
      if (seen !== exp)
      begin
         bad_count = bad_count + 1;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask

   task stop_test;
   begin
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask

   task rd(input sendOp, input [7:0] op, input [3:0] nAdr, input [31:0] adr,
           input [7:0] mode, input [4:0] nNib, input ok);
      integer   k;
      reg [31:0] full;
   begin
      full = (nAdr == 4'h6) ? {1'b0, bankReg[6:0], adr[23:0]} : adr;
      oeSeen = 1'b0;
      host_link_model_inst.xfer(sendOp, quadCmdMode, op, nAdr, adr, mode,
         dummyCfg == 4'h0 ? 4'h6 : dummyCfg, nNib);
      check(oeSeen, ok);
      for (k = 0; ok && k < nNib / 2; k = k + 1)
         check({host_link_model_inst.nib[2 * k], host_link_model_inst.nib[2 * k + 1]},
            byteAt(full + k));
   end
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count = bad_count + 1;
      stop_test;
   end

   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      quadEnable = 1'b1;
      quadCmdMode = 1'b0;
      bankReg = 8'h05;
      writeInProgress = 1'b0;
      dummyCfg = 4'h0;
      memReqReady = 1'b1;
      memRspValid = 1'b0;
      memRspData = 8'h00;
      oeSeen = 1'b0;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check({ioOe, contReadMode, memReqValid, memRspReady}, 32'h01);
      rd(1, 8'hED, 4'h6, 32'h00123457, 8'h00, 8, 1);
      bankReg = 8'h85;
      dummyCfg = 4'h4;
      rd(1, 8'hED, 4'h8, 32'h12345679, 8'h00, 6, 1);
      rd(1, 8'hEE, 4'h8, 32'hFFFFFFFE, 8'h00, 8, 1);
      rd(1, 8'hEE, 4'h8, 32'h00000103, 8'h00, 5, 1);
      rd(1, 8'hEE, 4'h8, 32'h00000201, 8'h00, 4, 1);
      quadCmdMode = 1'b1;
      quadEnable = 1'b0;
      rd(1, 8'hED, 4'h8, 32'h00000040, 8'hA5, 4, 1);
      check(contReadMode, 1);
      writeInProgress = 1'b1;
      rd(0, 8'h00, 4'h8, 32'h00000050, 8'hA0, 4, 0);
      check(contReadMode, 1);
      writeInProgress = 1'b0;
      rd(0, 8'h00, 4'h8, 32'h00000080, 8'hAF, 4, 1);
      check(contReadMode, 1);
      rd(0, 8'h00, 4'h8, 32'h000000C0, 8'h5A, 4, 1);
      check(contReadMode, 0);
      rd(1, 8'hEE, 4'h8, 32'h00000300, 8'h00, 4, 1);
      quadCmdMode = 1'b0;
      rd(1, 8'hED, 4'h8, 32'h00000400, 8'h00, 4, 0);
      quadEnable = 1'b1;
      rd(1, 8'h0B, 4'h8, 32'h00000400, 8'h00, 4, 0);
      writeInProgress = 1'b1;
      rd(1, 8'hEE, 4'h8, 32'h00000400, 8'h00, 4, 0);
      writeInProgress = 1'b0;
      check(stalls != 0, 1);
      stop_test;
   end
endmodule
